//--- design/cbp_pkg.sv
// Shared constants and types for the CPU bus port with interrupt chain
package cbp_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MUX_ADDR_W = 6;
  localparam int unsigned NM_ADDR_W  = 2;
  localparam int unsigned NUM_REGS   = 64;
  localparam int unsigned NUM_SRC    = 3;
  // Multiplexed register offsets; all but REG_LAST exist in this port's register file
  localparam logic [5:0] REG_MASTER_INT = 6'h00;
  localparam logic [5:0] REG_VEC_A      = 6'h02;
  localparam logic [5:0] REG_VEC_B      = 6'h03;
  localparam logic [5:0] REG_VEC_CT     = 6'h04;
  localparam logic [5:0] REG_LAST       = 6'h3f;
  // Non-multiplexed targets
  localparam logic [1:0] NM_PORT_C = 2'h0;
  localparam logic [1:0] NM_PORT_B = 2'h1;
  localparam logic [1:0] NM_PORT_A = 2'h2;
  localparam logic [1:0] NM_CTRL   = 2'h3;
  // Field positions in the master interrupt register
  localparam int unsigned MI_ENABLE_BIT = 7;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Spacing between non-multiplexed accesses, in peripheral clocks
  localparam int unsigned NM_GAP_CYC = 3;
  typedef enum logic [1:0] {
    CBP_IDLE  = 2'b00,
    CBP_ADDR  = 2'b01,
    CBP_XFER  = 2'b10,
    CBP_ACK   = 2'b11
  } cbp_state_e;
endpackage : cbp_pkg

//--- design/cbp_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module cbp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;
  // First stage feeds only the second stage; flops hold the pins relative to their idle levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      hold_q <= '0;
    end else begin
      meta_q <= d ^ rst_val;
      hold_q <= meta_q;
    end
  end
  // Idle levels come out during reset, so no false strobe follows it
  assign q = hold_q ^ rst_val;
endmodule : cbp_sync

//--- design/cbp_irq_chain.sv
// Interrupt pending, in-service and daisy-chain logic
`timescale 1ns/1ps
module cbp_irq_chain
  import cbp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [NUM_SRC-1:0] event_set,
  input  wire logic               int_enable,
  input  wire logic               ack_active,
  input  wire logic               vec_read,
  input  wire logic               chain_enable_in,
  input  wire logic [NUM_SRC-1:0] service_clear,
  output logic      [NUM_SRC-1:0] pending_flag,
  output logic      [NUM_SRC-1:0] in_service_flag,
  output logic      [1:0]         ack_src,
  output logic                    int_req,
  output logic                    chain_enable_out
);
  logic [NUM_SRC-1:0] grant;
  logic               any_pend;
  logic               any_srv;
  // Lowest index has highest priority
  always_comb begin
    grant = '0;
    ack_src = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending_flag[i]) begin
        grant = '0;
        grant[i] = 1'b1;
        ack_src = 2'(i);
      end
    end
  end
  assign any_pend = |pending_flag;
  assign any_srv  = |in_service_flag;
  // Pending and in-service flags per source
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        pending_flag[g]    <= 1'b0;
        in_service_flag[g] <= 1'b0;
      end else begin
        if (event_set[g]) begin
          pending_flag[g] <= 1'b1;
        end else if (vec_read && grant[g]) begin
          pending_flag[g] <= 1'b0;
        end
        if (vec_read && grant[g]) begin
          in_service_flag[g] <= 1'b1;
        end else if (service_clear[g]) begin
          in_service_flag[g] <= 1'b0;
        end
      end
    end
  end
  // Request and chain outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_req          <= 1'b0;
      chain_enable_out <= 1'b1;
    end else begin
      int_req          <= any_pend && int_enable;
      chain_enable_out <= chain_enable_in && !any_srv
                          && !(ack_active && any_pend);
    end
  end
endmodule : cbp_irq_chain

//--- design/cbp_port.sv
// CPU bus port, multiplexed and non-multiplexed variants, with interrupt chain
// Summary of operation
// - Capture address, acknowledge, select while strobe low
// - Selected when select low and select high
// - Address and transfer strobes together reset device
// - Read and write strobes together reset device
// - Latch six low address bits for register
// - Drive register on shared bus during read
// - Nonexistent register read leaves bus undriven
// - Write captures shared bus into addressed register
// - Chain out high only when chain allows
// - Request low when pending and enabled
// - Acknowledge with pending pulls chain out low
// - Vector on shared bus during acknowledge strobe
// - Vector read sets in-service, holds chain low
// - Request and wait outputs timed by clock
// - Two address lines pick four targets
// - Accept access only with chip enable low
// - Drive selected register while read strobe low
// - Capture data on write strobe falling edge
// - Vector on read only if chain in high
`timescale 1ns/1ps
module cbp_port
  import cbp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               mux_mode,
  input  wire logic               addr_latch_strobe_n,
  input  wire logic               transfer_strobe_n,
  input  wire logic               read_not_write,
  input  wire logic               select_low_n,
  input  wire logic               select_high,
  input  wire logic [DATA_W-1:0]  ad_in,
  output logic      [DATA_W-1:0]  ad_out,
  output logic                    ad_oe,
  input  wire logic [NM_ADDR_W-1:0] nm_addr,
  input  wire logic               chip_enable_n,
  input  wire logic               read_n,
  input  wire logic               write_n,
  input  wire logic               vector_ack_in_n,
  input  wire logic               chain_enable_in,
  output logic                    chain_enable_out,
  output logic                    int_req_out_n,
  output logic                    int_req_oe,
  input  wire logic [NUM_SRC-1:0] event_in,
  input  wire logic               dma_need,
  input  wire logic               wait_need,
  output logic                    dma_req_n,
  output logic                    wait_n,
  output logic                    self_reset
);
  localparam int unsigned SYNC_W = 14;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic               as_n_s;
  logic               ds_n_s;
  logic               rw_s;
  logic               cs0_n_s;
  logic               cs1_s;
  logic               ce_n_s;
  logic               rd_n_s;
  logic               wr_n_s;
  logic               ack_n_s;
  logic               iei_s;
  logic [1:0]         nma_s;
  logic               mode_s;
  logic               int_req;
  logic               as_n_p_q;
  logic               ds_n_p_q;
  logic               wr_n_p_q;
  logic               rd_n_p_q;
  logic [MUX_ADDR_W-1:0] addr_q;
  logic               cs0_lat_q;
  logic               ack_lat_q;
  logic [DATA_W-1:0]  regs_q [NUM_REGS];
  logic [DATA_W-1:0]  port_q [3];
  logic [NUM_SRC-1:0] pending_flag;
  logic [NUM_SRC-1:0] in_service_flag;
  logic [1:0]         ack_src;
  logic [DATA_W-1:0]  ad_out_d;
  logic               ad_oe_d;
  logic               soft_rst_d;
  logic               soft_rst_q;
  logic               int_rst;
  logic               mux_sel;
  logic               nm_sel;
  logic               mux_rd;
  logic               nm_rd;
  logic               mux_ack_rd;
  logic               nm_ack_rd;
  logic               vec_read;
  logic               vec_read_q;
  logic               ack_active;
  logic               mux_wr_fire;
  logic               nm_wr_fire;
  logic               reg_exists;
  logic [NUM_SRC-1:0] svc_clear;
  cbp_state_e         state_q;
  logic [1:0]         gap_q;

  // Control pins pass two flops before use; ad_in, event_in, dma_need and wait_need do not
  assign pins_raw = {mux_mode, nm_addr, chain_enable_in, vector_ack_in_n, write_n, read_n,
                     chip_enable_n, select_high, select_low_n, read_not_write,
                     transfer_strobe_n, addr_latch_strobe_n, 1'b0};
  cbp_sync #(.W(SYNC_W)) u_sync (
    .clock   (clock),
    .rst     (rst),
    .d       (pins_raw),
    .rst_val (14'h27de),
    .q       (pins_s)
  );
  assign {mode_s, nma_s, iei_s, ack_n_s, wr_n_s, rd_n_s, ce_n_s, cs1_s, cs0_n_s, rw_s,
          ds_n_s, as_n_s} = pins_s[SYNC_W-1:1];

  // Illegal strobe pairs reset the device
  assign soft_rst_d = mode_s ? (!as_n_s && !ds_n_s)
                             : (!rd_n_s && !wr_n_s);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_rst_d;
    end
  end
  assign int_rst = rst || soft_rst_q;

  // Strobe history for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      as_n_p_q <= 1'b1;
      ds_n_p_q <= 1'b1;
      wr_n_p_q <= 1'b1;
      rd_n_p_q <= 1'b1;
    end else begin
      as_n_p_q <= as_n_s;
      ds_n_p_q <= ds_n_s;
      wr_n_p_q <= wr_n_s;
      rd_n_p_q <= rd_n_s;
    end
  end

  // Address phase capture while address strobe is low
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      addr_q    <= '0;
      cs0_lat_q <= 1'b1;
      ack_lat_q <= 1'b1;
    end else if (mode_s && !as_n_s && ds_n_s) begin
      addr_q    <= ad_in[MUX_ADDR_W-1:0];
      cs0_lat_q <= cs0_n_s;
      ack_lat_q <= ack_n_s;
    end
  end

  // Bus phase tracker for the multiplexed cycle
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      state_q <= CBP_IDLE;
    end else begin
      case (state_q)
        CBP_IDLE: if (mode_s && !as_n_s) state_q <= CBP_ADDR;
        CBP_ADDR: if (as_n_s) state_q <= ack_lat_q ? CBP_XFER : CBP_ACK;
        CBP_XFER, CBP_ACK: if (!as_n_s) state_q <= CBP_ADDR;
        default: state_q <= CBP_IDLE;
      endcase
    end
  end

  // Selection and decode
  assign mux_sel    = mode_s && !cs0_lat_q && cs1_s;
  assign nm_sel     = !mode_s && !ce_n_s;
  assign reg_exists = addr_q <= REG_VEC_CT;
  assign mux_rd     = mux_sel && state_q == CBP_XFER && !ds_n_s && rw_s;
  assign mux_ack_rd = mode_s && state_q == CBP_ACK && !ds_n_s;
  assign nm_rd      = nm_sel && !rd_n_s && ack_n_s;
  assign nm_ack_rd  = !mode_s && !ack_n_s && !rd_n_s && iei_s;
  assign ack_active = mode_s ? state_q == CBP_ACK : !ack_n_s;
  assign vec_read   = (mux_ack_rd || nm_ack_rd) && (|pending_flag || vec_read_q) && iei_s;
  assign mux_wr_fire = mux_sel && state_q == CBP_XFER && !ds_n_s && ds_n_p_q && !rw_s;
  assign nm_wr_fire  = nm_sel && !wr_n_s && wr_n_p_q && rd_n_s && gap_q == '0;

  // Register file writes
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        port_q[i] <= REG_RESET;
      end
    end else if (mux_wr_fire && reg_exists) begin
      regs_q[addr_q] <= ad_in;
    end else if (nm_wr_fire) begin
      case (nma_s)
        NM_PORT_C: port_q[2] <= ad_in;
        NM_PORT_B: port_q[1] <= ad_in;
        NM_PORT_A: port_q[0] <= ad_in;
        default:   regs_q[REG_MASTER_INT] <= ad_in;
      endcase
    end
  end

  // Access spacing counter for the non-multiplexed bus
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      gap_q <= '0;
    end else if ((!rd_n_p_q && rd_n_s) || (!wr_n_p_q && wr_n_s)) begin
      gap_q <= 2'(NM_GAP_CYC - 1);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - 2'h1;
    end
  end

  // Read data and drive enable
  always_comb begin
    ad_out_d = '0;
    ad_oe_d  = 1'b0;
    if (vec_read) begin
      // Vector held for the whole strobe even after its pending flag clears
      ad_out_d = vec_read_q ? ad_out : regs_q[REG_VEC_A + 6'(ack_src)];
      ad_oe_d  = 1'b1;
    end else if (mux_rd && reg_exists) begin
      ad_out_d = regs_q[addr_q];
      ad_oe_d  = 1'b1;
    end else if (nm_rd) begin
      ad_oe_d = 1'b1;
      case (nma_s)
        NM_PORT_C: ad_out_d = port_q[2];
        NM_PORT_B: ad_out_d = port_q[1];
        NM_PORT_A: ad_out_d = port_q[0];
        default:   ad_out_d = regs_q[REG_MASTER_INT];
      endcase
    end
  end
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      ad_out     <= '0;
      ad_oe      <= 1'b0;
      vec_read_q <= 1'b0;
    end else begin
      ad_out     <= ad_out_d;
      ad_oe      <= ad_oe_d;
      vec_read_q <= vec_read;
    end
  end

  // In-service cleared by a multiplexed write of a one to its bit of the master register bits 2:0
  assign svc_clear = (mux_wr_fire && addr_q == REG_MASTER_INT) ? ad_in[NUM_SRC-1:0]
                                                                 : '0;

  cbp_irq_chain u_irq (
    .clock            (clock),
    .rst              (int_rst),
    .event_set        (event_in),
    .int_enable       (regs_q[REG_MASTER_INT][MI_ENABLE_BIT]),
    .ack_active       (ack_active),
    .vec_read         (vec_read && !vec_read_q),
    .chain_enable_in  (iei_s),
    .service_clear    (svc_clear),
    .pending_flag     (pending_flag),
    .in_service_flag  (in_service_flag),
    .ack_src          (ack_src),
    .int_req          (int_req),
    .chain_enable_out (chain_enable_out)
  );

  // Open-drain request and clocked handshake outputs
  always_ff @(posedge clock or posedge int_rst) begin
    if (int_rst) begin
      int_req_out_n <= 1'b1;
      int_req_oe    <= 1'b0;
      dma_req_n     <= 1'b1;
      wait_n        <= 1'b1;
      self_reset    <= 1'b0;
    end else begin
      int_req_out_n <= 1'b0;
      int_req_oe    <= int_req;
      dma_req_n     <= !(!mode_s && dma_need);
      wait_n        <= !(!mode_s && wait_need);
      self_reset    <= 1'b0;
    end
  end

  // Checks
  property p_irq;
    @(posedge clock) disable iff (int_rst)
      (|pending_flag && regs_q[REG_MASTER_INT][MI_ENABLE_BIT]) |-> ##2 int_req_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("request not raised");
  property p_chain;
    @(posedge clock) disable iff (int_rst)
      (|in_service_flag) |=> !chain_enable_out;
  endproperty
  a_chain: assert property (p_chain) else $error("chain high in service");
  property p_ack_block;
    @(posedge clock) disable iff (int_rst)
      (ack_active && |pending_flag) |=> !chain_enable_out;
  endproperty
  a_ack_block: assert property (p_ack_block) else $error("chain not blocked");
  property p_iei;
    @(posedge clock) disable iff (int_rst) !iei_s |=> !chain_enable_out;
  endproperty
  a_iei: assert property (p_iei) else $error("chain passes without input");
  property p_release;
    @(posedge clock) disable iff (int_rst)
      (!vec_read && !mux_rd && !nm_rd) |=> !ad_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus driven idle");
  property p_nomap;
    @(posedge clock) disable iff (int_rst)
      (mux_rd && !reg_exists && !vec_read) |=> !ad_oe;
  endproperty
  a_nomap: assert property (p_nomap) else $error("missing register driven");
  property p_sel;
    @(posedge clock) disable iff (int_rst) (mode_s && cs0_lat_q) |-> !mux_rd;
  endproperty
  a_sel: assert property (p_sel) else $error("read while unselected");
  property p_vec;
    @(posedge clock) disable iff (int_rst) $rose(vec_read) |=> in_service_flag != '0;
  endproperty
  a_vec: assert property (p_vec) else $error("in-service not set");
  c_mux_rd: cover property (@(posedge clock) mux_rd);
  c_nm_wr: cover property (@(posedge clock) nm_wr_fire);
  c_vec: cover property (@(posedge clock) vec_read);
endmodule : cbp_port

//--- bench/cbp_host.sv
// Host bus master and bus resolution model for the CPU bus port
`timescale 1ns/1ps
module cbp_host
  import cbp_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic [DATA_W-1:0]    ad_out,
  input  wire logic                 ad_oe,
  output logic      [DATA_W-1:0]    ad_in,
  output logic                      addr_latch_strobe_n,
  output logic                      transfer_strobe_n,
  output logic                      read_not_write,
  output logic                      select_low_n,
  output logic                      select_high,
  output logic      [NM_ADDR_W-1:0] nm_addr,
  output logic                      chip_enable_n,
  output logic                      read_n,
  output logic                      write_n,
  output logic                      vector_ack_in_n,
  output logic                      res_valid,
  output logic      [DATA_W:0]      res_data
);
  logic              hdrv;
  logic [DATA_W-1:0] hdata;
  logic [DATA_W-1:0] pat;

  // A bus nobody drives shows a pattern that changes every cycle
  always @(posedge clock) pat <= pat + 8'h35;
  assign ad_in = ad_oe ? ad_out : (hdrv ? hdata : pat);

  // Idle levels from time zero
  initial begin
    {addr_latch_strobe_n, transfer_strobe_n, read_n, write_n} = 4'hf;
    {chip_enable_n, vector_ack_in_n, select_low_n, read_not_write} = 4'hf;
    {select_high, hdrv, res_valid} = 3'h0;
    nm_addr = 2'h0;
    hdata = 8'h00;
    res_data = 9'h000;
    pat = 8'h00;
  end

  // Waits up to 8 cycles for the port to drive, then reports what it saw
  task automatic take();
    logic d;
    d = 1'b0;
    for (int i = 0; i < 8 && !d; i++) begin
      @(negedge clock);
      d = (ad_oe === 1'b1);
    end
    res_data = {d, d ? ad_out : 8'h00};
    res_valid = 1'b1;
    @(negedge clock);
    res_valid = 1'b0;
  endtask : take

  // Data phase shared by both variants, then release and access gap
  task automatic finish_acc(input logic rd);
    if (rd) take();
    else repeat (6) @(negedge clock);
    {transfer_strobe_n, read_n, write_n} = 3'h7;
    repeat (2) @(negedge clock);
    {select_high, hdrv} = 2'h0;
    {select_low_n, chip_enable_n, vector_ack_in_n} = 3'h7;
    repeat (6) @(negedge clock);  // Spacing between accesses
  endtask : finish_acc

  // Multiplexed cycle: address phase under the address strobe, then data
  task automatic mux_acc(input logic rd, input logic [5:0] a, input logic [7:0] d,
                         input logic sel, input logic ack);
    read_not_write = rd;  // Direction high for reads
    select_low_n = ~sel;
    select_high = sel;
    vector_ack_in_n = ~ack;  // Held for the whole cycle
    hdrv = 1'b1;
    hdata = {2'b00, a};
    addr_latch_strobe_n = 1'b0;
    repeat (6) @(negedge clock);
    addr_latch_strobe_n = 1'b1;
    repeat (3) @(negedge clock);  // Address stays until the synchronised strobe has risen
    hdrv = !rd;
    hdata = d;
    repeat (2) @(negedge clock);
    transfer_strobe_n = 1'b0;
    finish_acc(rd);
  endtask : mux_acc

  // Non-multiplexed cycle with separate strobes
  task automatic nm_acc(input logic rd, input logic [1:0] a, input logic [7:0] d,
                        input logic ce, input logic ack);
    nm_addr = a;
    chip_enable_n = ~ce;
    vector_ack_in_n = ~ack;  // Held for the whole cycle
    hdrv = !rd;
    hdata = d;
    repeat (2) @(negedge clock);
    read_n = !rd;
    write_n = rd;
    finish_acc(rd);
  endtask : nm_acc

  // Both strobes of a variant low together
  task automatic clash(input logic mux);
    if (mux) {addr_latch_strobe_n, transfer_strobe_n} = 2'h0;
    else {read_n, write_n} = 2'h0;
    repeat (4) @(negedge clock);
    {addr_latch_strobe_n, transfer_strobe_n, read_n, write_n} = 4'hf;
    repeat (8) @(negedge clock);
  endtask : clash
endmodule : cbp_host

//--- bench/testbench.sv
// Self-checking bench for the CPU bus port and interrupt chain
`timescale 1ns/1ps
module testbench;
  import cbp_pkg::*;
  logic                 clock, rst, mux_mode, chain_enable_in, dma_need, wait_need;
  logic [NUM_SRC-1:0]   event_in;
  logic                 obs_valid;
  logic [8:0]           obs_data;
  logic [7:0]           vec [3];
  logic [7:0]           v;
  logic [8:0]           q [$];
  int                   n_mismatch, compares;
  wire  [DATA_W-1:0]    ad_in, ad_out;
  wire  [NM_ADDR_W-1:0] nm_addr;
  wire  [8:0]           res_data;
  wire                  as_n, ds_n, rnw, cs_lo_n, cs_hi, ce_n, rd_n, wr_n, ack_n;
  wire                  ad_oe, ceo, irq_n, irq_oe, dma_n, wt_n, res_valid;
  wire                  int_line = irq_oe ? irq_n : 1'b1;  // Pulled up when released

  cbp_port DUT (.clock(clock), .rst(rst), .mux_mode(mux_mode), .addr_latch_strobe_n(as_n),
    .transfer_strobe_n(ds_n), .read_not_write(rnw), .select_low_n(cs_lo_n),
    .select_high(cs_hi), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .nm_addr(nm_addr),
    .chip_enable_n(ce_n), .read_n(rd_n), .write_n(wr_n), .vector_ack_in_n(ack_n),
    .chain_enable_in(chain_enable_in), .chain_enable_out(ceo), .int_req_out_n(irq_n),
    .int_req_oe(irq_oe), .event_in(event_in), .dma_need(dma_need), .wait_need(wait_need),
    .dma_req_n(dma_n), .wait_n(wt_n), .self_reset());
  cbp_host host (.clock(clock), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in),
    .addr_latch_strobe_n(as_n), .transfer_strobe_n(ds_n), .read_not_write(rnw),
    .select_low_n(cs_lo_n), .select_high(cs_hi), .nm_addr(nm_addr), .chip_enable_n(ce_n),
    .read_n(rd_n), .write_n(wr_n), .vector_ack_in_n(ack_n), .res_valid(res_valid),
    .res_data(res_data));

  initial clock = 1'b0;
  always #25 clock = ~clock;

  // Takes the oldest expectation off the queue whenever a result appears
  task automatic cmp(input logic [8:0] got);
    logic [8:0] e;
    e = (q.size() > 0) ? q.pop_front() : 9'hxxx;
    compares++;
    if (got !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: expected %h got %h", $time, e, got);
    end
  endtask : cmp
  always @(posedge clock) begin
    if (res_valid) cmp(res_data);
    if (obs_valid) cmp(obs_data);
  end

  // Publishes a level observation for one cycle; callers let pin synchronisers catch up first
  task automatic look(input logic [8:0] e, input logic [8:0] got);
    q.push_back(e);
    obs_data = got;
    obs_valid = 1'b1;
    @(negedge clock);
    obs_valid = 1'b0;
  endtask : look
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask : settle
  task automatic rd_mux(input logic [5:0] a, input logic sel, input logic ack,
                        input logic [8:0] e);
    q.push_back(e);
    host.mux_acc(1'b1, a, 8'h00, sel, ack);
  endtask : rd_mux
  task automatic rd_nm(input logic [1:0] a, input logic ce, input logic ack,
                       input logic [8:0] e);
    q.push_back(e);
    host.nm_acc(1'b1, a, 8'h00, ce, ack);
  endtask : rd_nm
  task automatic pulse(input logic [2:0] s);
    event_in = s;
    repeat (2) @(negedge clock);
    event_in = 3'h0;
    settle();
  endtask : pulse

  task automatic conclude();
    n_mismatch += q.size();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Cuts a hung run short
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end

  initial begin
    void'($urandom(32'hbb3c63fc));
    {rst, mux_mode, chain_enable_in} = 3'h7;
    {dma_need, wait_need, obs_valid} = 3'h0;
    {event_in, obs_data} = 12'h000;
    {n_mismatch, compares} = 0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    settle();
    look(9'h00f, {5'h0, ceo, int_line, dma_n, wt_n});  // Reset levels
    // Vector registers written and read back through the shared bus
    for (int i = 0; i < 3; i++) begin
      vec[i] = 8'($urandom());
      host.mux_acc(1'b0, REG_VEC_A + 6'(i), vec[i], 1'b1, 1'b0);  // Write
      rd_mux(REG_VEC_A + 6'(i), 1'b1, 1'b0, {1'b1, vec[i]});  // Readback
    end
    rd_mux(REG_LAST, 1'b1, 1'b0, 9'h000);  // Top unmapped offset
    rd_mux(6'h05 + 6'($urandom_range(58)), 1'b1, 1'b0, 9'h000);  // Unmapped
    rd_mux(REG_VEC_A, 1'b0, 1'b0, 9'h000);  // Not selected
    // Pending source 1 requests only once interrupts are enabled
    pulse(3'b010);
    look(9'h003, {7'h0, ceo, int_line});  // Disabled stays quiet
    host.mux_acc(1'b0, REG_MASTER_INT, 8'h80, 1'b1, 1'b0);
    settle();
    look(9'h002, {7'h0, ceo, int_line});  // Request with chain open
    rd_mux(6'h00, 1'b0, 1'b1, {1'b1, vec[1]});  // Vector on ack
    settle();
    look(9'h000, {8'h0, ceo});  // In service holds chain low
    host.mux_acc(1'b0, REG_MASTER_INT, 8'h82, 1'b1, 1'b0);
    settle();
    look(9'h001, {8'h0, ceo});  // Service cleared reopens chain
    chain_enable_in = 1'b0;
    settle();
    look(9'h000, {8'h0, ceo});  // Closed chain input
    chain_enable_in = 1'b1;
    // Non-multiplexed variant
    mux_mode = 1'b0;
    settle();
    host.nm_acc(1'b0, NM_CTRL, 8'h80, 1'b1, 1'b0);  // Write
    host.nm_acc(1'b0, NM_CTRL, 8'h00, 1'b0, 1'b0);  // Ignored unselected write
    rd_nm(NM_CTRL, 1'b1, 1'b0, 9'h180);  // Readback
    rd_nm(NM_CTRL, 1'b0, 1'b0, 9'h000);  // Unselected read
    pulse(3'b001);
    chain_enable_in = 1'b0;
    settle();
    rd_nm(NM_CTRL, 1'b0, 1'b1, 9'h000);  // Lower priority stays off bus
    chain_enable_in = 1'b1;
    settle();
    rd_nm(NM_CTRL, 1'b0, 1'b1, {1'b1, vec[0]});  // Highest priority vector
    {dma_need, wait_need} = 2'h3;
    settle();
    look(9'h000, {7'h0, dma_n, wt_n});  // Requests asserted
    {dma_need, wait_need} = 2'h0;
    settle();
    look(9'h003, {7'h0, dma_n, wt_n});  // Requests released
    host.clash(1'b0);
    rd_nm(NM_CTRL, 1'b1, 1'b0, {1'b1, REG_RESET});  // Strobe pair reset
    // Multiplexed strobe pair reset
    mux_mode = 1'b1;
    settle();
    v = 8'($urandom()) | 8'h01;
    host.mux_acc(1'b0, REG_VEC_B, v, 1'b1, 1'b0);
    rd_mux(REG_VEC_B, 1'b1, 1'b0, {1'b1, v});  // Readback
    host.clash(1'b1);
    rd_mux(REG_VEC_B, 1'b1, 1'b0, {1'b1, REG_RESET});  // Strobe pair reset
    for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge clock);
    conclude();
  end
endmodule : testbench
